// ==== dv/interrupt_priority_control_props.sv ====
module interrupt_priority_control_props
  import intc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [20:0] i_src_req,
  input wire logic i_ctl_we,
  input wire logic i_seq_ack,
  input wire logic o_take,
  input wire logic [2:0] o_disp_kind,
  input wire logic o_push_ctx,
  input wire logic o_bank_switch,
  input wire logic o_suspend,
  input wire logic o_opnd_take,
  input wire logic [20:0] o_pending,
  input wire logic [20:0] o_xfer_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Offer and flag checks
  // ********************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_disp_onehot: assert property (o_take |-> $onehot(o_disp_kind))
    else $error("dispatch kind not one-hot");
  a_vec_push: assert property (o_take && o_disp_kind == DISP_VECTOR
    |-> o_push_ctx && !o_bank_switch && !o_suspend)
    else $error("vector offer without stack push");
  a_ctx_bank: assert property (o_take && o_disp_kind == DISP_CTXSW
    |-> o_bank_switch && !o_push_ctx)
    else $error("context switch offer without bank switch");
  a_xfer_nosave: assert property (o_take && o_disp_kind == DISP_XFER
    |-> o_suspend && !o_push_ctx && !o_bank_switch)
    else $error("transfer offer saves context");
  // Offer must stand until the sequencer has answered
  a_take_holds: assert property (i_ce && o_take && !i_seq_ack
    && !$past(i_seq_ack) |=> o_take)
    else $error("offer withdrawn before acknowledge");
  a_opnd_vector: assert property (o_take && o_opnd_take
    |-> o_disp_kind == DISP_VECTOR)
    else $error("operand error not vectored");
  a_xfer_excl: assert property ((o_xfer_en & NO_XFER_MASK) == '0)
    else $error("transfer enabled on source without option");
  a_req_pending: assert property (i_ce && i_src_req != '0 && !i_ctl_we
    ##1 i_ce |=> (o_pending & $past(i_src_req, 2)) != '0)
    else $error("request not recorded as pending");
  c_ctxsw: cover property (o_take && o_disp_kind == DISP_CTXSW);
  c_xfer: cover property (o_take && o_disp_kind == DISP_XFER);
  c_opnd: cover property (o_take && o_opnd_take);
endmodule // interrupt_priority_control_props

bind interrupt_priority_control interrupt_priority_control_props u_props (
  .i_core_clk, .i_rst_n, .i_ce, .i_src_req, .i_ctl_we, .i_seq_ack,
  .o_take, .o_disp_kind, .o_push_ctx, .o_bank_switch, .o_suspend,
  .o_opnd_take, .o_pending, .o_xfer_en
);

// ==== dv/seq_partner.sv ====
module seq_partner
  import intc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_take,
  input wire logic [2:0] i_kind,
  input wire logic [3:0] i_ack_dly,
  input wire logic i_zero,
  output logic o_ack,
  output logic o_xfer_done,
  output logic o_xfer_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] kind_q;
  // ********************
  // Sequencer answer
  // ********************
  // Ack held for one edge only; zero line shows junk outside done
  initial begin
    o_ack = 1'b0;
    o_xfer_done = 1'b0;
    o_xfer_zero = ~i_zero;
    forever begin
      @(negedge i_core_clk);
      if (i_take === 1'b1) begin
        kind_q = i_kind;
        repeat (i_ack_dly) @(negedge i_core_clk);
        o_ack = 1'b1;
        @(negedge i_core_clk);
        o_ack = 1'b0;
        while (i_take === 1'b1) @(negedge i_core_clk);
        if (kind_q == DISP_XFER) begin
          repeat (3) @(negedge i_core_clk);
          o_xfer_done = 1'b1;
          o_xfer_zero = i_zero;
          @(negedge i_core_clk);
          o_xfer_done = 1'b0;
          o_xfer_zero = ~i_zero;
        end
      end
    end
  end
endmodule // seq_partner

// ==== dv/tb_top.sv ====
module tb_top;
  import intc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, ce, nmi, wdt, opnd, glob_en, we, mk, xf, cs, clr, nest;
  logic wfirst, ret, zero, ack, xdone, xzero, take, push, bank, susp;
  logic ntake, nwdt, otake;
  logic [20:0] req, pend, mask, xen;
  logic [4:0] sel, sid, s_src;
  logic [1:0] prio, nis;
  logic [2:0] be, kind, s_kind;
  logic [23:0] gdat;
  logic [3:0] dly, isl;
  logic [5:0] s_fl;
  int err_count, n_tests;
  interrupt_priority_control uut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_src_req(req), .i_nmi_pin(nmi), .i_wdt_ovf(wdt),
    .i_opnd_err(opnd), .i_global_accept_enable(glob_en), .i_ctl_we(we),
    .i_ctl_sel(sel), .i_ctl_mask(mk), .i_ctl_xfer(xf), .i_ctl_csw(cs),
    .i_ctl_prio(prio), .i_ctl_clr_req(clr), .i_gmask_be(be),
    .i_gmask_wdata(gdat), .i_lowest_level_nest_ctrl(nest),
    .i_wdt_first(wfirst), .i_seq_ack(ack), .i_svc_end(ret),
    .i_xfer_done(xdone), .i_xfer_zero(xzero), .o_take(take),
    .o_disp_kind(kind), .o_src_id(sid), .o_push_ctx(push),
    .o_bank_switch(bank), .o_suspend(susp), .o_nmi_take(ntake),
    .o_nmi_is_wdt(nwdt), .o_opnd_take(otake), .o_pending(pend),
    .o_mask(mask), .o_xfer_en(xen), .o_in_service_level(isl),
    .o_nmi_in_service(nis));
  seq_partner u_seq (.i_core_clk(clk), .i_take(take), .i_kind(kind),
    .i_ack_dly(dly), .i_zero(zero), .o_ack(ack), .o_xfer_done(xdone),
    .o_xfer_zero(xzero));
  // ********************
  // Helpers, entered just after a falling edge, except stop_test when the watchdog calls it after a rising edge
  // ********************
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task cfg(input int s, input logic m, x, c, input logic [1:0] p);
    sel = s[4:0];
    mk = m;
    xf = x;
    cs = c;
    prio = p;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(2);
  endtask
  task fire(input logic [20:0] r);
    req = r;
    cyc(1);
    req = '0;
    cyc(1);
  endtask
  task ret_svc;
    ret = 1'b1;
    cyc(1);
    ret = 1'b0;
    cyc(2);
  endtask
  // Waits for an offer, records it, then waits until it is withdrawn
  task offer;
    int i;
    for (i = 0; i < 20 && take !== 1'b1; i++) cyc(1);
    check(take, 1);
    s_kind = kind;
    s_src = sid;
    s_fl = {ntake, nwdt, otake, push, bank, susp};
    for (i = 0; i < 20 && take !== 1'b0; i++) cyc(1);
    cyc(2);
  endtask
  task quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      cyc(1);
      seen = seen | take;
    end
    check(seen, 0);
  endtask
  task nmis(input logic p, w);
    nmi = p;
    wdt = w;
    cyc(1);
    nmi = 1'b0;
    wdt = 1'b0;
    cyc(1);
  endtask
  // ********************
  // Clock, watchdog and scenarios
  // ********************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
  initial begin
    {rst_n, nmi, wdt, opnd, glob_en, we, mk, xf, cs, nest, wfirst, ret} = '0;
    {clr, zero, sel, prio, be, gdat, req} = '0;
    ce = 1'b1;
    dly = 4'h1;
    err_count = 0;
    n_tests = 0;
    cyc(16);
    rst_n = 1'b1;
    cyc(2);
    check(mask, MASK_RST);
    check(xen, 0);
    check(isl, ISL_RST);
    // Masked, then disabled, then accepted
    glob_en = 1'b1;
    fire(21'h8);
    quiet(8);
    check(pend, 21'h8);
    glob_en = 1'b0;
    cfg(3, 0, 0, 0, 2'h3);
    quiet(8);
    glob_en = 1'b1;
    offer;
    check(s_kind, DISP_VECTOR);
    check(s_src, 3);
    check(pend, 0);
    check(isl, 4'h8);
    ret_svc;
    check(isl, 0);
    // Levels, default order and nesting
    cfg(2, 0, 0, 0, 2'h3);
    cfg(5, 0, 0, 0, 2'h0);
    cfg(7, 0, 0, 0, 2'h0);
    fire(21'hA4);
    offer;
    check(s_src, 5);
    quiet(8);
    ret_svc;
    offer;
    check(s_src, 7);
    ret_svc;
    offer;
    check(s_src, 2);
    fire(21'h8);
    quiet(8);
    nest = 1'b1;
    offer;
    check(s_src, 3);
    ret_svc;
    ret_svc;
    nest = 1'b0;
    check(isl, 0);
    // Context switch with a slow sequencer
    dly = 4'h4;
    cfg(6, 0, 0, 1, 2'h1);
    fire(21'h40);
    offer;
    check(s_kind, DISP_CTXSW);
    check(s_fl, 6'h02);
    ret_svc;
    dly = 4'h1;
    // Transfer service with acceptance disabled
    glob_en = 1'b0;
    cfg(4, 0, 1, 0, 2'h3);
    check(xen, 21'h10);
    zero = 1'b1;
    fire(21'h10);
    offer;
    check(s_kind, DISP_XFER);
    check(s_fl, 6'h01);
    cyc(10);
    check(xen, 0);
    cfg(14, 1, 1, 0, 2'h3);
    check(xen, 0);
    // Grouped mask and per-source mask share bits
    be = 3'h1;
    cyc(1);
    be = 3'h0;
    cyc(2);
    check(mask, 21'h1FFF00);
    cfg(0, 1, 0, 0, 2'h3);
    check(mask, 21'h1FFF01);
    // Non-maskable order and blocking, acceptance still off
    nmis(1, 1);
    offer;
    check(s_fl[5:3], 3'h4);
    quiet(8);
    ret_svc;
    offer;
    check(s_fl[5:3], 3'h6);
    ret_svc;
    wfirst = 1'b1;
    nmis(1, 1);
    offer;
    check(s_fl[5:3], 3'h6);
    nmis(0, 1);
    quiet(8);
    ret_svc;
    offer;
    check(s_fl[5:3], 3'h6);
    ret_svc;
    offer;
    check(s_fl[5:3], 3'h4);
    ret_svc;
    check(nis, 0);
    // Watchdog nests in pin service; a return retires the newer one
    nmis(1, 0);
    offer;
    nmis(0, 1);
    offer;
    check(s_fl[5:3], 3'h6);
    ret_svc;
    check(nis, 2'h1);
    ret_svc;
    check(nis, 0);
    // Operand error ignores the disabled state
    opnd = 1'b1;
    cyc(1);
    opnd = 1'b0;
    cyc(1);
    offer;
    check(s_fl[3], 1);
    check(s_kind, DISP_VECTOR);
    ret_svc;
    // Software clear of a pending flag, then a frozen clock enable
    fire(21'h100);
    check(pend, 21'h100);
    clr = 1'b1;
    cfg(8, 1, 0, 0, 2'h3);
    clr = 1'b0;
    check(pend, 0);
    ce = 1'b0;
    fire(21'h200);
    ce = 1'b1;
    cyc(2);
    check(pend, 0);
    stop_test;
  end
endmodule // tb_top

// ==== logic/intc_pkg.sv ====
package intc_pkg;
  // ****************************************
  // Source counts and field widths
  // ****************************************
  localparam int NUM_SRC = 21;
  localparam int LVL_W = 2;
  localparam int NUM_LVL = 4;
  localparam int SRC_W = 5;
  localparam logic [1:0] LOWEST_LVL = 2'h3;
  // Sources without a data-transfer option (receive errors)
  localparam logic [20:0] NO_XFER_MASK = 21'h044000;
  // ****************************************
  // Reset values of the per-source fields and the in-service levels
  // ****************************************
  localparam logic [20:0] MASK_RST = 21'h1FFFFF;
  localparam logic [1:0] PRIO_RST = 2'h3;
  localparam logic XFER_RST = 1'b0;
  localparam logic CSW_RST = 1'b0;
  localparam logic [3:0] ISL_RST = 4'h0;
  // ****************************************
  // Dispatch kinds reported to the sequencer
  // ****************************************
  typedef enum logic [2:0] {
    DISP_VECTOR = 3'b001,
    DISP_CTXSW = 3'b010,
    DISP_XFER = 3'b100
  } disp_kind_e;
  // ****************************************
  // Dispatcher states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } disp_state_e;
endpackage

// ==== logic/interrupt_priority_control.sv ====
// Overview of operation
// R1: Bad operand in standby, watchdog-mode or location write: operand error.
// R2: Operand error ignores global enable and skips priority arbitration.
// R3: Non-maskable request comes from the pin or the watchdog.
// R4: Non-maskable ignores enable and levels, outranks everything.
// R5: No non-maskable accept while same or higher one is in service.
// R6: Maskable accepted only if unmasked and global enable set.
// R7: Maskable served by vector, context switch or transfer where allowed.
// R8: Equal-level simultaneous requests resolved by fixed source order.
// R9: Four programmable priority levels per source allow nesting.
// R10: Transfer-service requests ignore priority levels and global enable.
// R11: Vectored accept pushes PC and status then branches via table.
// R12: Transfer accept suspends execution, saves nothing.
// R13: Context switch selects bank, branches, stores PC and status.
// R14: Each source has request, mask, mode, switch-enable and level fields.
// R15: Grouped mask writes and per-source mask writes hit same bits.
// R16: In-service register records levels of requests being serviced.
// R17: Mode control decides whether level 3 requests nest.
// R18: Watchdog mode register selects pin versus watchdog priority.
// R19: Level 0 is highest; several sources may share a level.
// R20: Transfer counter reaching zero clears that source's mode flag.
// R21: Switch-enable flag routes request to context switching.
// R22: Accepting a request clears its pending flag.
module interrupt_priority_control
  import intc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Peripheral request pulses, bit 0 = default order 0
  input wire logic [20:0] i_src_req,
  // Non-maskable sources and operand-error detection
  input wire logic i_nmi_pin,
  input wire logic i_wdt_ovf,
  input wire logic i_opnd_err,
  // CPU global enable from the status word
  input wire logic i_global_accept_enable,
  // Per-source control register write port
  input wire logic i_ctl_we,
  input wire logic [4:0] i_ctl_sel,
  input wire logic i_ctl_mask,
  input wire logic i_ctl_xfer,
  input wire logic i_ctl_csw,
  input wire logic [1:0] i_ctl_prio,
  input wire logic i_ctl_clr_req,
  // Grouped mask write: word or byte lanes
  input wire logic [2:0] i_gmask_be,
  input wire logic [23:0] i_gmask_wdata,
  // Mode control and watchdog mode
  input wire logic i_lowest_level_nest_ctrl,
  input wire logic i_wdt_first,
  // Sequencer handshake
  input wire logic i_seq_ack,
  input wire logic i_svc_end,
  input wire logic i_xfer_done,
  input wire logic i_xfer_zero,
  output logic o_take,
  output logic [2:0] o_disp_kind,
  output logic [4:0] o_src_id,
  output logic o_push_ctx,
  output logic o_bank_switch,
  output logic o_suspend,
  output logic o_nmi_take,
  output logic o_nmi_is_wdt,
  output logic o_opnd_take,
  output logic [20:0] o_pending,
  output logic [20:0] o_mask,
  output logic [20:0] o_xfer_en,
  output logic [3:0] o_in_service_level,
  output logic [1:0] o_nmi_in_service
);
  // ****************************************
  // Per-source control fields
  // ****************************************
  logic [20:0] pend_reg;
  logic [20:0] mask_reg;
  logic [20:0] xfer_reg;
  logic [20:0] csw_reg;
  logic [1:0] prio_reg [NUM_SRC];
  logic [3:0] in_service_level_reg;
  logic [1:0] nmi_svc_reg; // bit0 pin, bit1 watchdog
  logic opnd_reg;
  logic nmi_pin_pend_reg;
  logic wdt_pend_reg;
  disp_state_e state_reg;
  logic [2:0] kind_reg;
  logic [4:0] sel_reg;
  logic sel_nmi_reg;
  logic sel_wdt_reg;
  logic sel_opnd_reg;
  logic [1:0] sel_lvl_reg;
  logic [20:0] clr_req;

  // ****************************************
  // Nesting limit from in-service levels
  // ****************************************
  // Current level is the best level in service; 4 means nothing.
  logic [2:0] cur_lvl;
  logic [2:0] nest_lim;
  assign cur_lvl = in_service_level_reg[0] ? 3'h0 :
                   in_service_level_reg[1] ? 3'h1 :
                   in_service_level_reg[2] ? 3'h2 :
                   in_service_level_reg[3] ? 3'h3 : 3'h4;
  // Level 3 may re-enter level 3 only if the mode control says so
  assign nest_lim = (cur_lvl == 3'h3 && i_lowest_level_nest_ctrl) ?
                    3'h4 : cur_lvl; // R17 R16 R9

  // ****************************************
  // Maskable arbitration
  // ****************************************
  logic [20:0] vec_ok;
  logic [20:0] xfer_ok;
  logic [1:0] best_lvl [NUM_SRC + 1];
  logic [4:0] best_id [NUM_SRC + 1];
  logic best_hit [NUM_SRC + 1];
  logic [4:0] x_id [NUM_SRC + 1];
  logic x_hit [NUM_SRC + 1];
  assign best_lvl[0] = LOWEST_LVL;
  assign best_id[0] = 5'h00;
  assign best_hit[0] = 1'b0;
  assign x_id[0] = 5'h00;
  assign x_hit[0] = 1'b0;
  genvar g;
  // Chain scans from highest index so order 0 wins ties
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_arb
      localparam int S = NUM_SRC - 1 - g;
      logic mine;
      assign vec_ok[S] = pend_reg[S] & ~mask_reg[S] & ~xfer_reg[S] &
                         i_global_accept_enable &
                         ({1'b0, prio_reg[S]} < nest_lim); // R6 R9
      assign xfer_ok[S] = pend_reg[S] & ~mask_reg[S] & xfer_reg[S] &
                          ~NO_XFER_MASK[S]; // R10 R7
      // Lower level number is higher priority, ties go to lower index
      assign mine = vec_ok[S] &
                    (!best_hit[g] || prio_reg[S] <= best_lvl[g]); // R19 R8
      assign best_hit[g+1] = best_hit[g] | vec_ok[S];
      assign best_lvl[g+1] = mine ? prio_reg[S] : best_lvl[g];
      assign best_id[g+1] = mine ? 5'(S) : best_id[g];
      assign x_hit[g+1] = x_hit[g] | xfer_ok[S];
      assign x_id[g+1] = xfer_ok[S] ? 5'(S) : x_id[g]; // R8
    end
  endgenerate

  // ****************************************
  // Non-maskable and operand-error selection
  // ****************************************
  logic pin_blk;
  logic wdt_blk;
  logic pin_ok;
  logic wdt_ok;
  logic nmi_go;
  logic nmi_wdt_pick;
  // Blocked while same or higher-ranked one is in service
  assign pin_blk = nmi_svc_reg[0] | (i_wdt_first & nmi_svc_reg[1]); // R5
  assign wdt_blk = nmi_svc_reg[1] | (~i_wdt_first & nmi_svc_reg[0]); // R5
  assign pin_ok = nmi_pin_pend_reg & ~pin_blk; // R4
  assign wdt_ok = wdt_pend_reg & ~wdt_blk;
  assign nmi_go = pin_ok | wdt_ok;
  assign nmi_wdt_pick = wdt_ok & (i_wdt_first | ~pin_ok); // R18

  // ****************************************
  // Request latching and control writes
  // ****************************************
  logic issue;
  logic xfer_end;
  assign issue = (state_reg == ST_IDLE) &&
                 (nmi_go || opnd_reg || best_hit[NUM_SRC] ||
                  x_hit[NUM_SRC]);
  assign xfer_end = (state_reg == ST_WAIT) && (kind_reg == DISP_XFER) &&
                    i_xfer_done && i_xfer_zero;

  // Clear of pending flag on acceptance or software clear
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_clr
      assign clr_req[g] = (issue && !nmi_go && !opnd_reg &&
                           ((x_hit[NUM_SRC] && x_id[NUM_SRC] == 5'(g)) ||
                            (!x_hit[NUM_SRC] &&
                             best_id[NUM_SRC] == 5'(g)))) ||
                          (i_ctl_we && i_ctl_clr_req &&
                           i_ctl_sel == 5'(g)); // R22
    end
  endgenerate

  // Mask bits: grouped path and per-source path share one bit
  logic [20:0] mask_next;
  logic [23:0] gm_be_bits;
  assign gm_be_bits = {{8{i_gmask_be[2]}}, {8{i_gmask_be[1]}},
                       {8{i_gmask_be[0]}}};
  always_comb begin
    mask_next = (mask_reg & ~gm_be_bits[20:0]) |
                (i_gmask_wdata[20:0] & gm_be_bits[20:0]); // R15
    if (i_ctl_we && i_ctl_sel < 5'(NUM_SRC)) begin
      mask_next[i_ctl_sel] = i_ctl_mask; // R15 R14
    end
  end

  // Pending, mode, switch-enable flags; pending set beats clear, transfer-end clear beats a mode write
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_reg <= '0;
      mask_reg <= MASK_RST;
      xfer_reg <= {NUM_SRC{XFER_RST}};
      csw_reg <= {NUM_SRC{CSW_RST}};
    end else if (i_ce) begin
      pend_reg <= (pend_reg & ~clr_req) | i_src_req; // R14 R22
      mask_reg <= mask_next;
      if (i_ctl_we && i_ctl_sel < 5'(NUM_SRC)) begin
        xfer_reg[i_ctl_sel] <= i_ctl_xfer & ~NO_XFER_MASK[i_ctl_sel];
        csw_reg[i_ctl_sel] <= i_ctl_csw; // R21
      end
      if (xfer_end) begin
        xfer_reg[sel_reg] <= 1'b0; // R20
      end
    end
  end

  // Priority fields, one per source
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_prio
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          prio_reg[g] <= PRIO_RST;
        end else if (i_ce && i_ctl_we && i_ctl_sel == 5'(g)) begin
          prio_reg[g] <= i_ctl_prio; // R9 R14
        end
      end
    end
  endgenerate

  // Non-maskable and operand-error pending; set beats clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_pin_pend_reg <= 1'b0;
      wdt_pend_reg <= 1'b0;
      opnd_reg <= 1'b0;
    end else if (i_ce) begin
      nmi_pin_pend_reg <= i_nmi_pin |
        (nmi_pin_pend_reg & ~(issue && nmi_go && !nmi_wdt_pick)); // R3
      wdt_pend_reg <= i_wdt_ovf |
        (wdt_pend_reg & ~(issue && nmi_go && nmi_wdt_pick)); // R3
      opnd_reg <= i_opnd_err |
        (opnd_reg & ~(issue && !nmi_go)); // R1 R2
    end
  end

  // ****************************************
  // Dispatcher
  // ****************************************
  // Order: non-maskable, operand error, transfer, maskable
  logic [2:0] next_kind;
  logic next_csw;
  assign next_csw = csw_reg[best_id[NUM_SRC]];
  assign next_kind = (nmi_go || opnd_reg) ? DISP_VECTOR :
                     x_hit[NUM_SRC] ? DISP_XFER :
                     next_csw ? DISP_CTXSW : DISP_VECTOR; // R4 R2 R21 R7

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      kind_reg <= DISP_VECTOR;
      sel_reg <= 5'h00;
      sel_nmi_reg <= 1'b0;
      sel_wdt_reg <= 1'b0;
      sel_opnd_reg <= 1'b0;
      sel_lvl_reg <= 2'h0;
    end else if (i_ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (issue) begin
            state_reg <= ST_ISSUE;
            kind_reg <= next_kind;
            sel_nmi_reg <= nmi_go;
            sel_wdt_reg <= nmi_wdt_pick;
            sel_opnd_reg <= !nmi_go && opnd_reg;
            sel_reg <= x_hit[NUM_SRC] ? x_id[NUM_SRC] :
                       best_id[NUM_SRC];
            sel_lvl_reg <= best_lvl[NUM_SRC];
          end
        end
        ST_ISSUE: begin
          if (i_seq_ack) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Vector/switch entries return at once; transfers wait done
          if (kind_reg != DISP_XFER || i_xfer_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // In-service tracking
  // ****************************************
  // One bit per level: nested entries at one level share that bit
  logic entry_mask;
  logic [3:0] lvl_bit;
  assign entry_mask = (state_reg == ST_ISSUE) && i_seq_ack &&
                      !sel_nmi_reg && !sel_opnd_reg &&
                      kind_reg != DISP_XFER;
  assign lvl_bit = 4'h1 << sel_lvl_reg;
  logic [3:0] end_bit;
  assign end_bit = (cur_lvl < 3'h4) ? (4'h1 << cur_lvl[1:0]) : 4'h0;
  logic [3:0] lvl_clr;
  logic [3:0] lvl_set;
  assign lvl_clr = (i_svc_end && nmi_svc_reg == 2'h0) ? end_bit : 4'h0;
  assign lvl_set = entry_mask ? lvl_bit : 4'h0;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_service_level_reg <= ISL_RST;
      nmi_svc_reg <= 2'h0;
    end else if (i_ce) begin
      // Service end retires the newest entry: NMI first, then level
      // Both in service: the higher-ranked one nested last, so it goes
      if (i_svc_end && nmi_svc_reg != 2'h0) begin
        nmi_svc_reg <= (&nmi_svc_reg) ? (i_wdt_first ? 2'h1 : 2'h2) :
                       2'h0; // R5
      end
      // A return and an entry in one cycle must both take effect
      in_service_level_reg <= (in_service_level_reg & ~lvl_clr) |
                              lvl_set; // R16
      if ((state_reg == ST_ISSUE) && i_seq_ack && sel_nmi_reg) begin
        nmi_svc_reg[sel_wdt_reg] <= 1'b1; // R5
      end
    end
  end

  // ****************************************
  // Registered outputs to the sequencer
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_take <= 1'b0;
      o_disp_kind <= DISP_VECTOR;
      o_src_id <= 5'h00;
      o_push_ctx <= 1'b0;
      o_bank_switch <= 1'b0;
      o_suspend <= 1'b0;
      o_nmi_take <= 1'b0;
      o_nmi_is_wdt <= 1'b0;
      o_opnd_take <= 1'b0;
      o_pending <= '0;
      o_mask <= MASK_RST;
      o_xfer_en <= '0;
      o_in_service_level <= ISL_RST;
      o_nmi_in_service <= 2'h0;
    end else if (i_ce) begin
      o_take <= (state_reg == ST_ISSUE) && !i_seq_ack;
      o_disp_kind <= kind_reg;
      o_src_id <= sel_reg;
      o_push_ctx <= (state_reg == ST_ISSUE) &&
                    kind_reg == DISP_VECTOR; // R11
      o_bank_switch <= (state_reg == ST_ISSUE) &&
                       kind_reg == DISP_CTXSW; // R13
      o_suspend <= (state_reg != ST_IDLE) &&
                   kind_reg == DISP_XFER; // R12
      o_nmi_take <= (state_reg == ST_ISSUE) && sel_nmi_reg;
      o_nmi_is_wdt <= sel_wdt_reg;
      o_opnd_take <= (state_reg == ST_ISSUE) && sel_opnd_reg;
      o_pending <= pend_reg;
      o_mask <= mask_reg;
      o_xfer_en <= xfer_reg;
      o_in_service_level <= in_service_level_reg;
      o_nmi_in_service <= nmi_svc_reg;
    end
  end
endmodule // interrupt_priority_control
